// File: verilog/hpt_host_port.sv
// Asynchronous strobe/acknowledge host port with scan-chain safe outputs.
// Assumes the core supplies read data and chain controls on the same clock.
// Summary of operation
// - Host holds chip select low to transfer; device accepts transfers only then.
// - With chip select high, data bus and acknowledge stay undriven.
// - Data bus is driven only while strobe is low during reads.
// - On writes acknowledge pulls low after data capture, releases at cycle end.
// - On reads acknowledge pulls low after read data is driven, released at end.
// - Upper data lanes exist only in the 32-bit build; base is 16 bits.
// - Interrupt output follows the interrupt event input, held low during internal reset.
// - Hi-Z flag output is high exactly when chain data output is undriven.
// - A redundant chain reset output mirrors the primary chain reset.
// - Both chain resets come from a majority-voted triple flip-flop.
// - After reset: mode-select 1, chain clock 0, data undriven, resets 0.
// - Boundary test-mode controls are gated by the device test reset input.
// - Hardware reset returns every register to its default.
// - Outside hardware reset, output-disable input high puts all test-access outputs undriven.
// - Hardware reset is synchronised and merged with software reset.
`timescale 1ns/1ps
module hpt_host_port
	import hpt_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              nrst,
	input  wire logic              clk_en,
	input  wire logic              chip_sel_n,
	input  wire logic              xfer_dir,
	input  wire logic              xfer_strobe_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] data_in,
	output logic      [DATA_W-1:0] data_out,
	output logic      [DATA_W-1:0] data_oe,
	output logic                   xfer_ack_n_out,
	output logic                   xfer_ack_n_oe,
	output logic                   irq,
	input  wire logic              irq_event,
	input  wire logic              soft_reset,
	input  wire logic              out_disable,
	input  wire logic              test_reset_n,
	input  wire logic              tap_extest,
	input  wire logic              tap_highz,
	output logic                   extest_gated,
	output logic                   highz_gated,
	input  wire logic [DATA_W-1:0] core_rdata,
	output logic                   core_wr,
	output logic                   core_rd,
	output hpt_req_s               core_req,
	input  wire hpt_chain_s        chain_ctl,
	output logic                   chain_mode_sel,
	output logic                   chain_mode_sel_oe,
	output logic                   chain_clk,
	output logic                   chain_clk_oe,
	output logic                   chain_data_out,
	output logic                   chain_data_out_oe,
	output logic                   chain_out_hiz_flag,
	output logic                   chain_reset_a,
	output logic                   chain_reset_a_oe,
	output logic                   chain_reset_b,
	output logic                   chain_reset_b_oe
);
	hpt_state_e        state_q;
	logic [1:0]        rst_sync_q;
	logic              internal_sync_reset_n;
	logic [1:0]        cs_sync_q;
	logic [1:0]        stb_sync_q;
	logic [1:0]        dir_sync_q;
	logic [ADDR_W-1:0] addr_meta_q;
	logic [ADDR_W-1:0] addr_sync_q;
	logic [DATA_W-1:0] wdata_meta_q;
	logic [DATA_W-1:0] wdata_sync_q;
	logic [2:0]        trst_tmr_q;
	logic              cyc_live;

	// Majority of three copies masks a single upset flip-flop.
	function automatic logic vote3(input logic [2:0] v);
		return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
	endfunction

	// Hardware reset is released synchronously; soft reset joins it.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'h0;
		end else if (clk_en) begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign internal_sync_reset_n = rst_sync_q[1] & ~soft_reset;

	// Host controls cross into the clock domain through two flops each.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cs_sync_q  <= SYNC_ONE;
			stb_sync_q <= SYNC_ONE;
			dir_sync_q <= 2'h0;
			addr_meta_q  <= '0;
			addr_sync_q  <= '0;
			wdata_meta_q <= '0;
			wdata_sync_q <= '0;
		end else if (clk_en) begin
			cs_sync_q  <= {cs_sync_q[0], chip_sel_n};
			stb_sync_q <= {stb_sync_q[0], xfer_strobe_n};
			dir_sync_q <= {dir_sync_q[0], xfer_dir};
			// Address and data pins cross too; they settle before the strobe does.
			addr_meta_q  <= addr;
			addr_sync_q  <= addr_meta_q;
			wdata_meta_q <= data_in;
			wdata_sync_q <= wdata_meta_q;
		end
	end

	// A cycle is live only with both chip select and strobe low.
	assign cyc_live = ~cs_sync_q[1] & ~stb_sync_q[1];

	// Transfer sequencing; the synchronised address and data are taken once the
	// synchronised strobe is seen, since the host sets them up before the strobe.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q  <= HPT_IDLE;
			core_req <= '0;
			core_wr  <= 1'b0;
			core_rd  <= 1'b0;
		end else if (!internal_sync_reset_n) begin
			state_q  <= HPT_IDLE;
			core_req <= '0;
			core_wr  <= 1'b0;
			core_rd  <= 1'b0;
		end else if (clk_en) begin
			core_wr <= 1'b0;
			core_rd <= 1'b0;
			case (state_q)
				HPT_IDLE: begin
					if (cyc_live) begin
						core_req.rd    <= dir_sync_q[1];
						core_req.addr  <= addr_sync_q;
						core_req.wdata <= wdata_sync_q;
						state_q        <= dir_sync_q[1] ? HPT_RD : HPT_WR;
						core_wr        <= ~dir_sync_q[1];
						core_rd        <= dir_sync_q[1];
					end
				end
				HPT_WR:  state_q <= HPT_ACK; // Data captured before ack.
				HPT_RD:  state_q <= HPT_ACK; // Read data driven before ack.
				HPT_ACK: begin
					if (!cyc_live) begin
						state_q <= HPT_IDLE; // Host ends cycle with strobe.
					end
				end
				default: state_q <= HPT_IDLE;
			endcase
		end
	end

	// Bus drivers; enables drop as soon as the cycle ends.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			data_out       <= '0;
			data_oe        <= '0;
			xfer_ack_n_out <= 1'b0;
			xfer_ack_n_oe  <= 1'b0;
		end else if (!internal_sync_reset_n) begin
			data_oe       <= '0;
			xfer_ack_n_oe <= 1'b0;
		end else if (clk_en) begin
			if (state_q == HPT_RD) begin
				data_out <= core_rdata;
				data_oe  <= '1;
			end else if (!cyc_live) begin
				data_oe  <= '0;
			end
			xfer_ack_n_out <= 1'b0; // Open drain: only ever pulls low.
			xfer_ack_n_oe  <= (state_q == HPT_ACK) && cyc_live;
		end
	end

	// Interrupt follows the core event, forced low by internal reset.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= irq_event & internal_sync_reset_n;
		end
	end

	// Triple chain-reset copies, forced low by internal reset.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			trst_tmr_q <= TMR_ZERO;
		end else if (!internal_sync_reset_n) begin
			trst_tmr_q <= TMR_ZERO;
		end else if (clk_en) begin
			trst_tmr_q <= {3{chain_ctl.reset_n}};
		end
	end

	// Chain pins with safe values in reset and undriven when disabled.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			chain_mode_sel     <= 1'b1;
			chain_clk          <= 1'b0;
			chain_data_out     <= 1'b0;
			chain_data_out_oe  <= 1'b0;
			chain_out_hiz_flag <= 1'b1;
			chain_reset_a      <= 1'b0;
			chain_reset_b      <= 1'b0;
			chain_mode_sel_oe  <= 1'b1;
			chain_clk_oe       <= 1'b1;
			chain_reset_a_oe   <= 1'b1;
			chain_reset_b_oe   <= 1'b1;
		end else if (clk_en) begin
			if (!internal_sync_reset_n) begin
				chain_mode_sel    <= 1'b1;
				chain_clk         <= 1'b0;
				chain_data_out_oe <= 1'b0;
			end else begin
				chain_mode_sel    <= chain_ctl.mode_sel;
				chain_clk         <= chain_ctl.clk;
				chain_data_out    <= chain_ctl.data;
				chain_data_out_oe <= ~chain_ctl.data_hiz & ~out_disable;
			end
			chain_out_hiz_flag <= ~internal_sync_reset_n | chain_ctl.data_hiz
				| out_disable;
			chain_reset_a     <= vote3(trst_tmr_q);
			chain_reset_b     <= vote3(trst_tmr_q);
			chain_mode_sel_oe <= ~out_disable;
			chain_clk_oe      <= ~out_disable;
			chain_reset_a_oe  <= ~out_disable;
			chain_reset_b_oe  <= ~out_disable;
		end
	end

	// Boundary test-mode controls cannot assert while test reset is low.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			extest_gated <= 1'b0;
			highz_gated  <= 1'b0;
		end else if (clk_en) begin
			extest_gated <= tap_extest & test_reset_n;
			highz_gated  <= tap_highz & test_reset_n;
		end
	end
endmodule

// File: verilog/hpt_pkg.sv
// Package for the host parallel port and scan-safe output block.
// Assumes a single 200 MHz system clock domain.
package hpt_pkg;
	localparam int DATA_W     = 16;    // Base data width; 32 for the wide macro.
	localparam int ADDR_W     = 5;
	localparam int LANE_LO_W  = 16;
	localparam logic [1:0] SYNC_ONE = 2'h3;
	localparam logic [2:0] TMR_ZERO = 3'h0;

	// Port transfer states.
	typedef enum logic [1:0] {
		HPT_IDLE = 2'h0,
		HPT_WR   = 2'h1,
		HPT_RD   = 2'h2,
		HPT_ACK  = 2'h3
	} hpt_state_e;

	// Request seen from the host side after synchronising.
	typedef struct packed {
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} hpt_req_s;

	// Scan chain control requested by the core.
	typedef struct packed {
		logic mode_sel;
		logic clk;
		logic data;
		logic data_hiz;
		logic reset_n;
	} hpt_chain_s;
endpackage

// File: dv/hpt_host_port_properties.sv
// Checker for the host port, bound onto every instance of the top module.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module hpt_host_port_properties import hpt_pkg::*; (
	input wire logic              clock,
	input wire logic              nrst,
	input wire logic              clk_en,
	input wire logic              soft_reset,
	input wire logic              chip_sel_n,
	input wire logic              xfer_strobe_n,
	input wire logic              test_reset_n,
	input wire logic [DATA_W-1:0] data_oe,
	input wire logic              xfer_ack_n_oe,
	input wire logic              extest_gated,
	input wire logic              highz_gated,
	input wire logic              core_wr,
	input wire hpt_req_s          core_req,
	input wire hpt_chain_s        chain_ctl,
	input wire logic              chain_data_out_oe,
	input wire logic              chain_out_hiz_flag,
	input wire logic              chain_reset_a,
	input wire logic              chain_reset_b
);
	logic [2:0] up_q;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// Settled cycles; the voter lag is judged only once this saturates, past any reset.
	always_ff @(posedge clock or negedge nrst)
		if (!nrst) up_q <= 3'h0;
		else if (soft_reset || !clk_en) up_q <= 3'h0;
		else if (up_q != 3'h7) up_q <= up_q + 3'h1;
	a_cs_hiz_bus: assert property (chip_sel_n [*5] |-> data_oe == '0 && !xfer_ack_n_oe)
		else $error("bus or ack driven while deselected");
	a_strobe_hiz_bus: assert property (xfer_strobe_n [*5] |-> data_oe == '0)
		else $error("bus driven while strobe high");
	a_rd_ack_data: assert property ($rose(xfer_ack_n_oe) && core_req.rd |-> data_oe == '1)
		else $error("read ack without driven data");
	a_wr_ack_after: assert property ($rose(xfer_ack_n_oe) && !core_req.rd |-> $past(core_wr, 2))
		else $error("write ack not two cycles after capture");
	a_hiz_flag_tracks: assert property (chain_out_hiz_flag == !chain_data_out_oe)
		else $error("hiz flag disagrees with data drive");
	a_reset_twin_equal: assert property (chain_reset_a == chain_reset_b)
		else $error("chain reset copies differ");
	a_tmr_lag_two: assert property (up_q == 3'h7 |-> chain_reset_a == $past(chain_ctl.reset_n, 2))
		else $error("chain reset not voted copy two cycles late");
	a_test_gate_off: assert property (clk_en && !test_reset_n |=> !extest_gated && !highz_gated)
		else $error("test controls pass while test reset low");
	c_write: cover property (core_wr);
	c_read_ack: cover property ($rose(xfer_ack_n_oe) && core_req.rd);
	c_reset_high: cover property (up_q == 3'h7 && chain_reset_a);
endmodule
bind hpt_host_port hpt_host_port_properties u_props (.*);

// File: dv/hpt_host_model.sv
// Host processor model: one strobe cycle at a time on the port.
// Assumes falling-edge drive; the ack wire has a pull-up.
`timescale 1ns/1ps
module hpt_host_model import hpt_pkg::*; (
	input  wire logic              clock,
	input  wire logic [DATA_W-1:0] data_out,
	input  wire logic [DATA_W-1:0] data_oe,
	input  wire logic              xfer_ack_n_oe,
	output logic                   chip_sel_n,
	output logic                   xfer_dir,
	output logic                   xfer_strobe_n,
	output logic      [ADDR_W-1:0] addr,
	output logic      [DATA_W-1:0] data_in
);
	// Open-drain ack resolved against its pull-up.
	wire ack_n = xfer_ack_n_oe ? 1'b0 : 1'b1;
	initial {chip_sel_n, xfer_strobe_n, xfer_dir, addr, data_in} = '1;
	// Bounded wait for ack so a dead port cannot hang the host.
	task automatic cycle(input logic sel_n, rd, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rv, output logic ok);
		ok = 0;
		rv = '0;
		@(negedge clock);
		{chip_sel_n, xfer_dir, addr, data_in} = {sel_n, rd, a, rd ? ~wd : wd};
		@(negedge clock);
		xfer_strobe_n = 0;
		for (int n = 0; n < 20 && !ok; n++) begin
			@(negedge clock);
			ok = !ack_n;
			rv = (data_oe === '1) ? data_out : ~data_in;
		end
		xfer_strobe_n = 1;
		@(negedge clock);
		{chip_sel_n, data_in} = {1'b1, ~data_in};
		for (int n = 0; n < 20 && !ack_n; n++) @(negedge clock);
	endtask
endmodule

// File: dv/tb_hpt_host_port.sv
// Bench: host strobe cycles, then chain outputs, gating and resets.
// Assumes the design, checker and host model compile first.
`timescale 1ns/1ps
module tb_hpt_host_port import hpt_pkg::*;;
	logic clock = 0, nrst = 0, clk_en = 1, irq_event = 0, soft_reset = 0, out_disable = 0;
	logic test_reset_n = 0, tap_extest = 1, tap_highz = 1, chip_sel_n, xfer_dir, xfer_strobe_n;
	logic xfer_ack_n_out, xfer_ack_n_oe, irq, extest_gated, highz_gated, core_wr, core_rd;
	logic chain_mode_sel, chain_mode_sel_oe, chain_clk, chain_clk_oe, chain_data_out;
	logic chain_data_out_oe, chain_out_hiz_flag, chain_reset_a, chain_reset_a_oe;
	logic chain_reset_b, chain_reset_b_oe;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] data_in, data_out, data_oe, core_rdata;
	hpt_req_s core_req, wr_seen;
	hpt_chain_s chain_ctl = 5'h12; // Safe request: mode select high, data undriven.
	int num_errors = 0, n_compared = 0, n_wr = 0, n_rd = 0, cycles = 0;
	hpt_host_port dut (.*);
	hpt_host_model host (.*);
	// Read data follows the address so the bench can rebuild it.
	assign core_rdata = {core_req.addr, 11'h2c5};
	always #2.5 clock = ~clock;
	// Core writes sampled away from the launching edge; timeout cuts a hang.
	always @(negedge clock) begin
		cycles++;
		if (core_wr === 1'b1) begin
			n_wr++;
			wr_seen = core_req;
		end
		if (core_rd === 1'b1) begin
			n_rd++;
		end
		if (cycles == 2000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic t_safe;
		chk("safe", 6'h24, {chain_mode_sel, chain_clk, chain_data_out_oe,
			chain_out_hiz_flag, chain_reset_a, chain_reset_b});
		chk("bus_oe", 0, {data_oe, xfer_ack_n_oe});
	endtask
	// Write the top address, read straight after, then strobe while deselected.
	task automatic t_xfer;
		logic [DATA_W-1:0] rv;
		logic ok;
		host.cycle(1'b0, 1'b0, 5'h1f, 16'hc3a5, rv, ok);
		chk("wr_ack", 1, ok);
		chk("wr_req", {1'b0, 5'h1f, 16'hc3a5}, wr_seen);
		chk("ack_level", 0, xfer_ack_n_out);
		host.cycle(1'b0, 1'b1, 5'h0a, 16'h0, rv, ok);
		chk("rd_ack", 1, ok);
		chk("rd_data", {5'h0a, 11'h2c5}, rv);
		host.cycle(1'b1, 1'b0, 5'h03, 16'h1234, rv, ok);
		chk("cs_ack", 0, ok);
		chk("cs_wr", 1, n_wr);
		chk("rd_pulse", 1, n_rd);
	endtask
	// Chain requests pass, then output disable, gating and a held soft reset.
	task automatic t_chain;
		chain_ctl = 5'h0d;
		irq_event = 1;
		test_reset_n = 1;
		repeat (5) @(negedge clock);
		chk("chain", 6'h1b, {chain_mode_sel, chain_clk, chain_data_out,
			chain_out_hiz_flag, chain_reset_a, chain_reset_b});
		chk("irq", 1, irq);
		chk("gated", 3, {extest_gated, highz_gated});
		out_disable = 1;
		test_reset_n = 0;
		repeat (2) @(negedge clock);
		chk("oe_off", 1, {chain_mode_sel_oe, chain_clk_oe, chain_data_out_oe,
			chain_reset_a_oe, chain_reset_b_oe, chain_out_hiz_flag});
		chk("gated", 0, {extest_gated, highz_gated});
		out_disable = 0;
		soft_reset = 1;
		repeat (3) @(negedge clock);
		t_safe();
		chk("irq_rst", 0, irq);
		soft_reset = 0;
	endtask
	task automatic stop_test;
		if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge clock);
		t_safe();
		nrst = 1;
		repeat (4) @(negedge clock);
		t_safe();
		chk("width", 16, DATA_W);
		t_xfer();
		t_chain();
		stop_test();
	end
endmodule
